// [src/hpc_playback_ctrl.sv]
// Playback control registers and the engine they steer
// Operation
// R01: Setting the trigger bit starts the process chosen by the mode.
// R02: Sequencer mode plays the waveform identifiers of the eight slots.
// R03: Trigger bit reads one until the process ends, then clears itself.
// R04: Writing zero to the trigger bit aborts running playback at once.
// R05: External trigger edge sets the trigger bit just like a host write.
// R06: Trigger also starts calibration or diagnostics in those modes.
// R07: Library samples step every 5 ms, or 1 ms with the interval bit set.
// R08: Strength field scales library effects to 100, 75, 50 or 25 percent.
// R09: No strength scaling is applied in live host-driven mode.
// R10: Live mode drives the load with the live drive register value.
// R11: Host may rewrite live value anytime; each new value is used.
// R12: Live drive value is a signed two's-complement byte.
// R13: Sequencer starts at first slot, stops at zero or after eight.
// R14: A slot with delay flag set idles its value times 10 ms.
`timescale 1ns/1ps
`default_nettype none
module hpc_playback_ctrl #(
  parameter int MS_CYCLES = hpc_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic ext_trig,
  input wire logic [1:0] mode,
  input wire logic [63:0] slot_data,
  input wire logic wave_done,
  input wire logic signed [7:0] lib_sample,
  input wire logic proc_done,
  output logic wave_start,
  output logic [6:0] wave_id,
  output logic sample_step,
  output logic proc_start,
  output logic proc_is_diag,
  output logic signed [7:0] drive_out
);
  hpc_pkg::hpc_state_e state;
  hpc_pkg::hpc_state_e next_state;
  logic [7:0] trig_reg;
  logic [7:0] playback_config;
  logic [7:0] live_drive_value;
  logic ext_trig_q;
  logic [2:0] slot_idx;
  logic [2:0] step_cnt;
  logic [10:0] wait_ms;
  hpc_tick_if tick_if ();

  hpc_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .clk(clk),
    .rst(rst),
    .t(tick_if.gen)
  );
  assign tick_if.run = (state != hpc_pkg::ST_IDLE);

  // Register decode
  wire wr_trig = reg_wr && (reg_addr == hpc_pkg::ADDR_TRIG);
  wire wr_cfg = reg_wr && (reg_addr == hpc_pkg::ADDR_CFG);
  wire wr_live = reg_wr && (reg_addr == hpc_pkg::ADDR_LIVE);
  wire trig_rise = ext_trig && !ext_trig_q;
  wire go_req = (wr_trig && reg_wdata[hpc_pkg::GO_BIT]) || trig_rise; // [R05]
  wire start = (state == hpc_pkg::ST_IDLE) && go_req; // [R01]
  // Abort only reaches playback; calibration runs to its own end
  wire playing = (state == hpc_pkg::ST_LOAD) || (state == hpc_pkg::ST_PLAY)
    || (state == hpc_pkg::ST_WAIT) || (state == hpc_pkg::ST_LIVE);
  wire abort = wr_trig && !reg_wdata[hpc_pkg::GO_BIT] && playing; // [R04]

  // Current slot fields
  wire [7:0] slot = slot_data[slot_idx*8 +: 8];
  wire slot_delay_flag = slot[hpc_pkg::SLOT_DELAY_BIT];
  wire [6:0] slot_val = slot[6:0];
  wire last_slot = (slot_idx == 3'(hpc_pkg::SLOT_COUNT - 1));
  wire [2:0] interval_ms = playback_config[hpc_pkg::INTERVAL_BIT]
    ? hpc_pkg::INTERVAL_FAST_MS : hpc_pkg::INTERVAL_SLOW_MS; // [R07]
  wire step_due = tick_if.tick && (step_cnt + 3'h1 >= interval_ms);
  wire wait_end = tick_if.tick && (wait_ms == 11'h001);

  // Strength scaling of library samples
  wire [1:0] library_strength_scale =
    playback_config[hpc_pkg::STRENGTH_LSB +: 2];
  wire signed [7:0] s_half = lib_sample >>> 1;
  wire signed [7:0] s_quarter = lib_sample >>> 2;
  wire signed [7:0] scaled = (library_strength_scale == 2'h0) ? lib_sample
    : (library_strength_scale == 2'h1) ? lib_sample - s_quarter
    : (library_strength_scale == 2'h2) ? s_half
    : s_quarter; // [R08]
  // Live value bypasses the scaler entirely
  wire signed [7:0] next_drive = (state == hpc_pkg::ST_LIVE)
    ? $signed(live_drive_value) // [R09] [R10] [R11] [R12]
    : (state == hpc_pkg::ST_PLAY) ? scaled : 8'sh00;

  // Read data selection, unmapped offsets read zero
  wire [7:0] rd_mux = (reg_addr == hpc_pkg::ADDR_TRIG) ? trig_reg
    : (reg_addr == hpc_pkg::ADDR_CFG) ? playback_config
    : (reg_addr == hpc_pkg::ADDR_LIVE) ? live_drive_value : 8'h00;

  // Engine sequencing
  always_comb begin
    next_state = state;
    case (state)
      hpc_pkg::ST_IDLE: begin
        if (start) begin
          if (mode == hpc_pkg::MODE_SEQ) begin
            next_state = hpc_pkg::ST_LOAD; // [R02]
          end
          else if (mode == hpc_pkg::MODE_LIVE) next_state = hpc_pkg::ST_LIVE;
          else next_state = hpc_pkg::ST_PROC; // [R06]
        end
      end
      hpc_pkg::ST_LOAD: begin
        if (abort) next_state = hpc_pkg::ST_IDLE;
        else if (slot_val == 7'h00) next_state = hpc_pkg::ST_IDLE; // [R13]
        else if (slot_delay_flag) next_state = hpc_pkg::ST_WAIT; // [R14]
        else next_state = hpc_pkg::ST_PLAY;
      end
      hpc_pkg::ST_PLAY: begin
        if (abort) next_state = hpc_pkg::ST_IDLE;
        else if (wave_done) next_state = last_slot ? hpc_pkg::ST_IDLE
          : hpc_pkg::ST_LOAD; // [R13]
      end
      hpc_pkg::ST_WAIT: begin
        if (abort) next_state = hpc_pkg::ST_IDLE;
        else if (wait_end) next_state = last_slot ? hpc_pkg::ST_IDLE
          : hpc_pkg::ST_LOAD; // [R13]
      end
      hpc_pkg::ST_LIVE: begin
        if (abort) next_state = hpc_pkg::ST_IDLE;
      end
      hpc_pkg::ST_PROC: begin
        if (proc_done) next_state = hpc_pkg::ST_IDLE;
      end
      default: next_state = hpc_pkg::ST_IDLE;
    endcase
  end

  // State, trigger bit and registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= hpc_pkg::ST_IDLE;
      trig_reg <= hpc_pkg::RST_TRIG;
      playback_config <= hpc_pkg::RST_CFG;
      live_drive_value <= hpc_pkg::RST_LIVE;
      ext_trig_q <= 1'b0;
    end else begin
      state <= next_state;
      ext_trig_q <= ext_trig;
      if (wr_trig) trig_reg[7:1] <= reg_wdata[7:1];
      // Bit follows the engine, so it self-clears at the end
      trig_reg[hpc_pkg::GO_BIT] <= (next_state != hpc_pkg::ST_IDLE); // [R03]
      if (wr_cfg) playback_config <= reg_wdata;
      if (wr_live) live_drive_value <= reg_wdata; // [R11]
    end
  end

  // Slot walk, step and wait counters
  always_ff @(posedge clk) begin
    if (rst || start) begin
      slot_idx <= 3'h0; // [R13]
      step_cnt <= 3'h0;
      wait_ms <= 11'h000;
    end else begin
      if ((state == hpc_pkg::ST_PLAY || state == hpc_pkg::ST_WAIT)
          && next_state == hpc_pkg::ST_LOAD) slot_idx <= slot_idx + 3'h1;
      if (state == hpc_pkg::ST_LOAD) begin
        wait_ms <= 11'(slot_val) * hpc_pkg::WAIT_UNIT_MS; // [R14]
        step_cnt <= 3'h0;
      end else if (state == hpc_pkg::ST_WAIT && tick_if.tick) begin
        wait_ms <= wait_ms - 11'h001;
      end
      if (state == hpc_pkg::ST_PLAY && tick_if.tick) begin
        step_cnt <= step_due ? 3'h0 : step_cnt + 3'h1; // [R07]
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      wave_start <= 1'b0;
      wave_id <= 7'h00;
      sample_step <= 1'b0;
      proc_start <= 1'b0;
      proc_is_diag <= 1'b0;
      drive_out <= 8'sh00;
    end else begin
      if (reg_rd) reg_rdata <= rd_mux;
      wave_start <= (state == hpc_pkg::ST_LOAD)
        && (next_state == hpc_pkg::ST_PLAY); // [R02]
      if (state == hpc_pkg::ST_LOAD) wave_id <= slot_val;
      sample_step <= (state == hpc_pkg::ST_PLAY) && step_due; // [R07]
      proc_start <= (next_state == hpc_pkg::ST_PROC)
        && (state == hpc_pkg::ST_IDLE); // [R06]
      if (start) proc_is_diag <= (mode == hpc_pkg::MODE_DIAG);
      drive_out <= next_drive;
    end
  end

  // Checks on the engine
  go_tracks_busy_a: assert property (@(posedge clk) disable iff (rst) // [R03]
    trig_reg[hpc_pkg::GO_BIT] == (state != hpc_pkg::ST_IDLE))
    else $error("trigger bit does not match engine activity");
  start_launch_a: assert property (@(posedge clk) disable iff (rst) // [R01]
    (state == hpc_pkg::ST_IDLE && go_req) |=> state != hpc_pkg::ST_IDLE)
    else $error("trigger did not start a process");
  abort_stops_a: assert property (@(posedge clk) disable iff (rst) // [R04]
    abort |=> (state == hpc_pkg::ST_IDLE && !trig_reg[hpc_pkg::GO_BIT]))
    else $error("clearing trigger did not abort playback");
  ext_trig_go_a: assert property (@(posedge clk) disable iff (rst) // [R05]
    (state == hpc_pkg::ST_IDLE && ext_trig && !ext_trig_q)
    |=> trig_reg[hpc_pkg::GO_BIT])
    else $error("external trigger did not set trigger bit");
  live_drive_a: assert property (@(posedge clk) disable iff (rst) // [R10]
    (state == hpc_pkg::ST_LIVE) |=> drive_out == $past(live_drive_value))
    else $error("live drive value not on output");
  half_scale_a: assert property (@(posedge clk) disable iff (rst) // [R08]
    (state == hpc_pkg::ST_PLAY && library_strength_scale == 2'h2)
    |=> drive_out == ($past(lib_sample) >>> 1))
    else $error("half strength scaling wrong");
  step_on_tick_a: assert property (@(posedge clk) disable iff (rst) // [R07]
    (state == hpc_pkg::ST_PLAY && tick_if.tick
     && playback_config[hpc_pkg::INTERVAL_BIT]) |=> sample_step)
    else $error("fast interval missed a sample step");
  zero_slot_stop_a: assert property (@(posedge clk) disable iff (rst) // [R13]
    (state == hpc_pkg::ST_LOAD && slot_val == 7'h00)
    |=> state == hpc_pkg::ST_IDLE)
    else $error("sequencer passed a zero identifier");
  wait_load_a: assert property (@(posedge clk) disable iff (rst) // [R14]
    (state == hpc_pkg::ST_LOAD && slot_delay_flag && slot_val != 7'h00
     && !abort)
    |=> (state == hpc_pkg::ST_WAIT
     && wait_ms == 11'($past(slot_val)) * hpc_pkg::WAIT_UNIT_MS))
    else $error("delay slot loaded wrong wait");
  proc_launch_a: assert property (@(posedge clk) disable iff (rst) // [R06]
    (state == hpc_pkg::ST_IDLE && go_req && mode[1])
    |=> (state == hpc_pkg::ST_PROC && proc_start))
    else $error("trigger did not launch calibration or diagnostics");
endmodule : hpc_playback_ctrl
`default_nettype wire

// [src/hpc_pkg.sv]
// Constants and types shared by the playback control block
package hpc_pkg;
  // Register offsets on the device's register port
  localparam logic [7:0] ADDR_TRIG = 8'h0c;
  localparam logic [7:0] ADDR_CFG = 8'h0d;
  localparam logic [7:0] ADDR_LIVE = 8'h0e;
  localparam logic [7:0] ADDR_SLOT_FIRST = 8'h0f;
  localparam logic [7:0] ADDR_SLOT_LAST = 8'h16;
  // Reset values
  localparam logic [7:0] RST_TRIG = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_LIVE = 8'h7f;
  // Field positions
  localparam int GO_BIT = 0;
  localparam int INTERVAL_BIT = 5;
  localparam int STRENGTH_LSB = 0;
  localparam int SLOT_DELAY_BIT = 7;
  localparam int SLOT_COUNT = 8;
  // Timing: clock period and the millisecond base
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [2:0] INTERVAL_SLOW_MS = 3'h5;
  localparam logic [2:0] INTERVAL_FAST_MS = 3'h1;
  localparam logic [10:0] WAIT_UNIT_MS = 11'h00a;
  // Process selection, driven by the mode setting
  typedef enum logic [1:0] {
    MODE_SEQ = 2'b00,
    MODE_LIVE = 2'b01,
    MODE_CAL = 2'b10,
    MODE_DIAG = 2'b11
  } hpc_mode_e;
  // Playback engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_PLAY = 3'b010,
    ST_WAIT = 3'b011,
    ST_LIVE = 3'b100,
    ST_PROC = 3'b101
  } hpc_state_e;
endpackage : hpc_pkg

// [src/hpc_tick_if.sv]
// Millisecond timebase link between engine and divider
`timescale 1ns/1ps
`default_nettype none
interface hpc_tick_if;
  logic run;
  logic tick;
  modport gen (input run, output tick);
  modport use_side (output run, input tick);
endinterface : hpc_tick_if
`default_nettype wire

// [src/hpc_ms_tick.sv]
// Divider giving a one-cycle pulse every millisecond while running
`timescale 1ns/1ps
`default_nettype none
module hpc_ms_tick #(
  parameter int CYCLES = hpc_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  hpc_tick_if.gen t
);
  localparam int CW = $clog2(CYCLES) + 1;
  logic [CW-1:0] cnt;

  // Restarts from zero each time the engine leaves idle
  always_ff @(posedge clk) begin
    if (rst || !t.run) begin
      cnt <= '0;
      t.tick <= 1'b0;
    end else if (cnt == CW'(CYCLES - 1)) begin
      cnt <= '0;
      t.tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      t.tick <= 1'b0;
    end
  end
endmodule : hpc_ms_tick
`default_nettype wire

// [tb/hpc_lib_model.sv]
// Library and calibration stand-in facing the playback engine
`timescale 1ns/1ps
`default_nettype none
module hpc_lib_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic wave_start,
  input wire logic sample_step,
  input wire logic proc_start,
  output logic wave_done,
  output logic signed [7:0] lib_sample,
  output logic proc_done
);
  logic playing;
  logic busy;
  logic [1:0] steps;
  logic [4:0] pcnt;
  logic [7:0] junk;
  // Outside a waveform the sample churns, so stale use shows
  assign lib_sample = playing ? 8'sh40 : junk;
  // Waveform ends after three steps; cal/diag after 20 cycles
  always_ff @(posedge clk) begin
    junk <= junk + 8'h35;
    wave_done <= 1'b0;
    proc_done <= 1'b0;
    if (rst) begin
      playing <= 1'b0;
      busy <= 1'b0;
      junk <= 8'ha5;
    end else begin
      if (wave_start) begin
        playing <= 1'b1;
        steps <= 2'h0;
      end else if (playing && sample_step) begin
        steps <= steps + 2'h1;
        playing <= (steps != 2'h2);
        wave_done <= (steps == 2'h2);
      end
      if (proc_start) begin
        busy <= 1'b1;
        pcnt <= 5'h00;
      end else if (busy) begin
        pcnt <= pcnt + 5'h01;
        busy <= (pcnt != 5'h13);
        proc_done <= (pcnt == 5'h13);
      end
    end
  end
endmodule : hpc_lib_model
`default_nettype wire

// [tb/test_haptic_playback_control_regs.sv]
// Self-checking bench for the playback control registers
`timescale 1ns/1ps
`default_nettype none
module test_haptic_playback_control_regs;
  localparam int MSC = 10;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} hpc_row_s;
  hpc_row_s rows[5] = '{'{8'h0d, 8'he3, 8'he3}, '{8'h0e, 8'h80, 8'h80},
    '{8'h0c, 8'hf0, 8'hf0}, '{8'h20, 8'h55, 8'h00}, '{8'h0c, 8'h00, 8'h00}};
  logic [7:0] gains[4] = '{8'h40, 8'h30, 8'h20, 8'h10};
  logic clk, rst, reg_wr, reg_rd, ext_trig, wave_done, proc_done;
  logic wave_start, sample_step, proc_start, proc_is_diag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [1:0] mode;
  logic [63:0] slot_data;
  logic [6:0] wave_id;
  logic signed [7:0] lib_sample, drive_out;
  logic [6:0] ids[$];
  int st[$];
  int num_errors = 0, tests_run = 0, cyc = 0, last = 0, gap = 0;
  hpc_playback_ctrl #(.MS_CYCLES(MSC)) dut_u (.clk(clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_trig(ext_trig),
    .mode(mode), .slot_data(slot_data), .wave_done(wave_done),
    .lib_sample(lib_sample), .proc_done(proc_done),
    .wave_start(wave_start), .wave_id(wave_id), .sample_step(sample_step),
    .proc_start(proc_start), .proc_is_diag(proc_is_diag),
    .drive_out(drive_out));
  hpc_lib_model lib_u (.clk(clk), .rst(rst), .wave_start(wave_start),
    .sample_step(sample_step), .proc_start(proc_start),
    .wave_done(wave_done), .lib_sample(lib_sample), .proc_done(proc_done));
  // Clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Record started waveforms and the spacing of sample steps
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wave_start === 1'b1) begin
      ids.push_back(wave_id);
      st.push_back(cyc);
    end
    if (sample_step === 1'b1) begin
      gap <= cyc - last;
      last <= cyc;
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 q = reg_rdata;
  endtask : rd
  // Poll the trigger bit with a bound; running out ends the run
  task automatic idle_wait;
    int n;
    for (n = 0; n < 2000; n++) begin
      rd(8'h0c, v);
      if (v[0] === 1'b0) break;
    end
    if (n == 2000) begin
      num_errors++;
      close_out();
    end
  endtask : idle_wait
  task automatic play(input logic [63:0] s, input logic [7:0] c);
    @(posedge clk);
    slot_data <= s;
    wr(8'h0d, c);
    ids.delete();
    st.delete();
    wr(8'h0c, 8'h01);
  endtask : play
  task automatic close_out;
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 8'h00; ext_trig = 1'b0; mode = 2'h0; slot_data = 64'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    // Strength steps, single slot, slow interval, then one fast-interval run
    for (int g = 0; g < 4; g++) begin
      play(64'h05, 8'(g));
      repeat (20) @(posedge clk);
      #1 chk(drive_out, gains[g]);
      idle_wait();
      chk(8'(ids.size()), 8'h01);
      chk({1'b0, ids[0]}, 8'h05);
      chk(8'(gap), 8'h32);
    end
    play(64'h05, 8'h20);
    idle_wait();
    chk(8'(gap), 8'h0a);
    // Delay slot between two waveforms, then all eight slots
    play(64'h0007_8305, 8'h00);
    idle_wait();
    chk({1'b0, ids[1]}, 8'h07);
    chk(8'(st[1] - st[0] >= 440 && st[1] - st[0] < 600), 8'h01);
    play(64'h0807_0605_0403_0201, 8'h00);
    idle_wait();
    chk(8'(ids.size()), 8'h08);
    // Abort of sequencer playback
    play(64'h0201, 8'h00);
    repeat (20) @(posedge clk);
    wr(8'h0c, 8'h00);
    repeat (300) @(posedge clk);
    rd(8'h0c, v);
    chk(v, 8'h00);
    chk(8'(ids.size()), 8'h01);
    // Live drive ignores strength and follows rewrites
    @(posedge clk);
    mode <= 2'h1;
    wr(8'h0d, 8'h03);
    wr(8'h0e, 8'h85);
    wr(8'h0c, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk(drive_out, 8'h85);
    rd(8'h0c, v);
    chk(v, 8'h01);
    wr(8'h0e, 8'hfe);
    repeat (2) @(posedge clk);
    #1 chk(drive_out, 8'hfe);
    wr(8'h0c, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk(drive_out, 8'h00);
    // External trigger edge
    @(posedge clk);
    mode <= 2'h0;
    slot_data <= 64'h09;
    ids.delete();
    @(posedge clk);
    ext_trig <= 1'b1;
    @(posedge clk);
    ext_trig <= 1'b0;
    rd(8'h0c, v);
    chk(v, 8'h01);
    idle_wait();
    chk({1'b0, ids[0]}, 8'h09);
    // Calibration and diagnostics
    for (int m = 2; m < 4; m++) begin
      @(posedge clk);
      mode <= 2'(m);
      wr(8'h0c, 8'h01);
      #1 chk({7'h0, proc_start}, 8'h01);
      chk({7'h0, proc_is_diag}, 8'(m == 3));
      idle_wait();
    end
    // Reset while diagnostics run must still restore every default
    wr(8'h0c, 8'hf1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h0c, v);
    chk(v, 8'h00);
    rd(8'h0d, v);
    chk(v, 8'h00);
    rd(8'h0e, v);
    chk(v, 8'h7f);
    chk({7'h0, proc_is_diag}, 8'h00);
    close_out();
  end
endmodule : test_haptic_playback_control_regs
`default_nettype wire
